// ===== bfpt_config.sv
// Global pulse timing configuration: PLL enable, bit-period divider and pattern length.
// Assumes a register write/read port fed by the serial configuration front end.
//
// Summary of operation
// - PLL runs while its enable bit is one, stays off while zero.
// - The 7-bit divider sets how long each output pattern bit lasts.
// - Divider one holds every pattern bit for one master clock period.
// - Divider sixteen holds every pattern bit for sixteen master clock periods.
// - Divider zero gives the largest division, 128 master periods per bit.
// - One length code applies to all channels and both pattern register kinds.
// - Codes 000 to 011 mean 4, 8, 16 and 24 pattern bits.
// - Codes 100 to 111 mean 32, 40, 48 and 64 pattern bits.
// - A written bit count differing from the length is flagged as a mismatch.
module bfpt_config
	import bfpt_pkg::*;
(
	input  wire logic              mclk,
	input  wire logic              rst_n,
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [DATA_W-1:0] reg_rdata,
	input  wire logic              fire_en,
	input  wire logic              pat_write_done,
	input  wire logic [BITS_W-1:0] pat_bits_written,
	output logic                   pll_enable,
	output logic                   firing,
	output logic                   bit_strobe,
	output logic      [BITS_W-1:0] bit_index,
	output logic      [BITS_W-1:0] pattern_bits,
	output logic                   pattern_done,
	output logic                   length_mismatch
);
	////////////////////////////////////////////////////////////////////////////////
	bfpt_tick_if tick_if ();

	logic              pll_en_reg;
	logic              pll_en_next;
	logic [DIV_W-1:0]  div_reg;
	logic [DIV_W-1:0]  div_next;
	logic [2:0]        len_reg;
	logic [2:0]        len_next;
	logic [DATA_W-1:0] rdata_reg;
	logic [DATA_W-1:0] rdata_next;
	logic              hit;

	assign hit = (reg_addr == TOP_CONTROL_ADDR);

	always_comb begin
		pll_en_next = pll_en_reg;
		div_next    = div_reg;
		len_next    = len_reg;
		rdata_next  = rdata_reg;
		if (reg_wr && hit) begin
			pll_en_next = reg_wdata[PLL_EN_POS];
			div_next    = reg_wdata[DIV_LSB +: DIV_W];
			len_next    = reg_wdata[LEN_LSB +: LEN_CODE_W];
		end
		if (reg_rd) begin
			rdata_next = '0;
			if (hit) begin
				rdata_next[PLL_EN_POS]             = pll_en_reg;
				rdata_next[DIV_LSB +: DIV_W]       = div_reg;
				rdata_next[LEN_LSB +: LEN_CODE_W]  = len_reg;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pll_en_reg <= TOP_CONTROL_RESET[PLL_EN_POS];
			div_reg    <= TOP_CONTROL_RESET[DIV_LSB +: DIV_W];
			len_reg    <= TOP_CONTROL_RESET[LEN_LSB +: LEN_CODE_W];
			rdata_reg  <= '0;
		end else begin
			pll_en_reg <= pll_en_next;
			div_reg    <= div_next;
			len_reg    <= len_next;
			rdata_reg  <= rdata_next;
		end
	end

	assign reg_rdata  = rdata_reg;
	assign pll_enable = pll_en_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Length decode shared by every channel.
	function automatic logic [BITS_W-1:0] len_bits(input logic [2:0] code);
		logic [BITS_W-1:0] n;
		n = PAT_LEN_4;
		unique case (code)
			3'b000: n = PAT_LEN_4;
			3'b001: n = PAT_LEN_8;
			3'b010: n = PAT_LEN_16;
			3'b011: n = PAT_LEN_24;
			3'b100: n = PAT_LEN_32;
			3'b101: n = PAT_LEN_40;
			3'b110: n = PAT_LEN_48;
			3'b111: n = PAT_LEN_64;
		endcase
		return n;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	bfpt_state_t       state_reg;
	bfpt_state_t       state_next;
	logic              fire_d_reg;
	logic [DIV_W-1:0]  act_div_reg;
	logic [DIV_W-1:0]  act_div_next;
	logic [BITS_W-1:0] act_len_reg;
	logic [BITS_W-1:0] act_len_next;
	logic [BITS_W-1:0] idx_reg;
	logic [BITS_W-1:0] idx_next;
	logic              done_reg;
	logic              done_next;
	logic              mis_reg;
	logic              mis_next;

	// Settings are copied on every cycle spent idle and held once firing starts, so a pattern in flight never
	// changes speed or length halfway through.
	always_comb begin
		state_next   = state_reg;
		act_div_next = act_div_reg;
		act_len_next = act_len_reg;
		idx_next     = idx_reg;
		done_next    = 1'b0;
		mis_next     = mis_reg;
		unique case (state_reg)
			BFPT_IDLE: begin
				act_div_next = div_reg;
				act_len_next = len_bits(len_reg);
				if (fire_en && !fire_d_reg) begin
					idx_next   = '0;
					state_next = BFPT_FIRE;
				end
			end
			BFPT_FIRE: begin
				if (tick_if.bit_tick) begin
					if (idx_reg == act_len_reg - 7'h01) begin
						done_next  = 1'b1;
						state_next = BFPT_DONE;
					end else begin
						idx_next = idx_reg + 7'h01;
					end
				end
				if (!fire_en) begin
					state_next = BFPT_IDLE;
				end
			end
			BFPT_DONE: begin
				if (!fire_en) begin
					state_next = BFPT_IDLE;
				end
			end
		endcase
		if (pat_write_done) begin
			mis_next = (pat_bits_written != len_bits(len_reg));
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg   <= BFPT_IDLE;
			fire_d_reg  <= 1'b0;
			act_div_reg <= TOP_CONTROL_RESET[DIV_LSB +: DIV_W];
			act_len_reg <= PAT_LEN_64;
			idx_reg     <= '0;
			done_reg    <= 1'b0;
			mis_reg     <= 1'b0;
		end else begin
			state_reg   <= state_next;
			fire_d_reg  <= fire_en;
			act_div_reg <= act_div_next;
			act_len_reg <= act_len_next;
			idx_reg     <= idx_next;
			done_reg    <= done_next;
			mis_reg     <= mis_next;
		end
	end

	assign tick_if.divider = act_div_reg;
	assign tick_if.run     = (state_reg == BFPT_FIRE);

	bfpt_bit_timer u_timer (
		.mclk  (mclk),
		.rst_n (rst_n),
		.tick  (tick_if.gen)
	);

	assign firing          = (state_reg == BFPT_FIRE);
	assign bit_strobe      = tick_if.bit_tick;
	assign bit_index       = idx_reg;
	assign pattern_bits    = act_len_reg;
	assign pattern_done    = done_reg;
	assign length_mismatch = mis_reg;
endmodule

// ===== bfpt_pkg.sv
// Shared constants for the pulse timing configuration block.
// Assumes a single master clock; one divider count equals one master clock period.
package bfpt_pkg;
	localparam int          ADDR_W          = 5;
	localparam int          DATA_W          = 14;
	localparam int          DIV_W           = 7;
	localparam int          LEN_CODE_W      = 3;
	localparam int          BITS_W          = 7;
	localparam logic [4:0]  TOP_CONTROL_ADDR = 5'h1a;
	localparam int          PLL_EN_POS      = 10;
	localparam int          DIV_LSB         = 3;
	localparam int          LEN_LSB         = 0;
	localparam logic [13:0] TOP_CONTROL_RESET = 14'h047f;
	localparam logic [7:0]  DIV_ZERO_COUNT  = 8'h80;
	localparam logic [6:0]  PAT_LEN_4       = 7'h04;
	localparam logic [6:0]  PAT_LEN_8       = 7'h08;
	localparam logic [6:0]  PAT_LEN_16      = 7'h10;
	localparam logic [6:0]  PAT_LEN_24      = 7'h18;
	localparam logic [6:0]  PAT_LEN_32      = 7'h20;
	localparam logic [6:0]  PAT_LEN_40      = 7'h28;
	localparam logic [6:0]  PAT_LEN_48      = 7'h30;
	localparam logic [6:0]  PAT_LEN_64      = 7'h40;

	typedef enum logic [2:0] {
		BFPT_IDLE = 3'b001,
		BFPT_FIRE = 3'b010,
		BFPT_DONE = 3'b100
	} bfpt_state_t;
endpackage

// ===== bfpt_tick_if.sv
// Carries the bit-period settings to the bit-rate generator and its tick back.
// Assumes both ends sit on the same master clock.
interface bfpt_tick_if;
	logic [6:0] divider;
	logic       run;
	logic       bit_tick;
	modport ctrl (output divider, output run, input bit_tick);
	modport gen  (input divider, input run, output bit_tick);
endinterface

// ===== bfpt_bit_timer.sv
// Bit-period generator: one enable pulse at the end of every pattern bit.
// Assumes the divider is held steady while run is high.
module bfpt_bit_timer
	import bfpt_pkg::*;
(
	input  wire logic  mclk,
	input  wire logic  rst_n,
	bfpt_tick_if.gen   tick
);
	logic [7:0] period;
	logic [7:0] cnt_reg;
	logic [7:0] cnt_next;

	assign period = (tick.divider == 7'h00) ? DIV_ZERO_COUNT : {1'b0, tick.divider};

	always_comb begin
		cnt_next = cnt_reg;
		if (!tick.run) begin
			cnt_next = period - 8'h01;
		end else if (cnt_reg == 8'h00) begin
			cnt_next = period - 8'h01;
		end else begin
			cnt_next = cnt_reg - 8'h01;
		end
	end

	assign tick.bit_tick = tick.run && (cnt_reg == 8'h00);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= 8'h00;
		end else begin
			cnt_reg <= cnt_next;
		end
	end
endmodule

// ===== bfpt_config_chk.sv
// Port checker for the pulse timing configuration block.
// Assumes it is bound into every bfpt_config instance.
module bfpt_config_chk
	import bfpt_pkg::*;
(
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic [4:0]  reg_addr,
	input wire logic [13:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [13:0] reg_rdata,
	input wire logic        fire_en,
	input wire logic        pat_write_done,
	input wire logic [6:0]  pat_bits_written,
	input wire logic        pll_enable,
	input wire logic        firing,
	input wire logic        bit_strobe,
	input wire logic [6:0]  bit_index,
	input wire logic [6:0]  pattern_bits,
	input wire logic        pattern_done,
	input wire logic        length_mismatch
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [6:0] LUT [8] = '{PAT_LEN_4, PAT_LEN_8, PAT_LEN_16, PAT_LEN_24,
		PAT_LEN_32, PAT_LEN_40, PAT_LEN_48, PAT_LEN_64};
	logic [13:0] cfg_reg;
	logic [7:0]  per_reg;
	logic [7:0]  cnt_reg;
	wire         wr_hit = reg_wr && reg_addr == TOP_CONTROL_ADDR;
	wire  [7:0]  div_n  = cfg_reg[9:3] == 7'h00 ? 8'h80 : {1'b0, cfg_reg[9:3]};
	wire  [13:0] rd_exp = reg_addr == TOP_CONTROL_ADDR ? cfg_reg : 14'h0000;
	wire  [6:0]  len_at = LUT[cfg_reg[2:0]];
	wire         mis    = pat_bits_written != len_at;
	// The bit period is latched while idle, so mid-firing writes must not move it.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_reg <= TOP_CONTROL_RESET;
			per_reg <= 8'h00;
			cnt_reg <= 8'h00;
		end else begin
			cfg_reg <= wr_hit ? {3'b000, reg_wdata[10:0]} : cfg_reg;
			per_reg <= firing ? per_reg : div_n;
			cnt_reg <= (!firing || bit_strobe) ? 8'h00 : cnt_reg + 8'h01;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	sequence done_seq;
		!firing && pattern_done ##1 !pattern_done;
	endsequence
	chk_pll_follow: assert property (wr_hit |=> pll_enable == cfg_reg[10])
		else $error("pll enable wrong");
	chk_read_back: assert property (reg_rd |=> reg_rdata == $past(rd_exp))
		else $error("read data wrong");
	chk_len_latch: assert property ($rose(firing) |-> pattern_bits == $past(len_at))
		else $error("pattern length wrong");
	chk_fire_start: assert property ($rose(fire_en) && !firing && !pattern_done |=> firing)
		else $error("firing did not start");
	chk_bit_period: assert property (firing |-> bit_strobe == (cnt_reg == per_reg - 8'h01))
		else $error("bit period wrong");
	chk_index_step: assert property (bit_strobe && fire_en && bit_index != pattern_bits - 7'h01
		|=> bit_index == $past(bit_index) + 7'h01)
		else $error("bit index wrong");
	chk_last_done: assert property (bit_strobe && fire_en && bit_index == pattern_bits - 7'h01
		|=> done_seq)
		else $error("pattern end wrong");
	chk_len_hold: assert property (firing && $past(firing) |-> $stable(pattern_bits))
		else $error("pattern length moved during firing");
	chk_mismatch_flag: assert property (pat_write_done |=> length_mismatch == $past(mis))
		else $error("mismatch flag wrong");
endmodule
bind bfpt_config bfpt_config_chk chk (.*);

// ===== bfpt_host.sv
// Host model driving the register port and pattern write reports.
// Assumes one bench process calls its tasks, right after an mclk edge.
module bfpt_host (
	input  wire logic   mclk,
	output logic [4:0]  reg_addr,
	output logic [13:0] reg_wdata,
	output logic        reg_wr,
	output logic        reg_rd,
	output logic        pat_write_done,
	output logic [6:0]  pat_bits_written
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		{reg_addr, reg_wdata, reg_wr, reg_rd, pat_write_done, pat_bits_written} = '0;
	end
	task automatic acc(input logic [4:0] a, input logic [13:0] d, input logic w);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= w;
		reg_rd <= !w;
		@(posedge mclk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		reg_wdata <= ~d;
		@(posedge mclk);
	endtask
	task automatic pat(input logic [6:0] n);
		pat_bits_written <= n;
		pat_write_done <= 1'b1;
		@(posedge mclk);
		pat_write_done <= 1'b0;
		pat_bits_written <= ~n;
		@(posedge mclk);
	endtask
	task automatic restart(input logic [13:0] d);
		acc(5'h1a, d & 14'h3bff, 1'b1);
		acc(5'h1a, d | 14'h0400, 1'b1);
	endtask
endmodule

// ===== bfpt_config_test.sv
// Self-checking bench for the pulse timing configuration block.
// Assumes the host model drives the register port and pattern reports.
module bfpt_config_test
	import bfpt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        mclk = 1'b0;
	logic        rst_n = 1'b0;
	logic        fire_en = 1'b0;
	logic [4:0]  reg_addr;
	logic [13:0] reg_wdata, reg_rdata;
	logic        reg_wr, reg_rd, pat_write_done, firing, bit_strobe;
	logic        pll_enable, pattern_done, length_mismatch;
	logic [6:0]  pat_bits_written, bit_index, pattern_bits;
	int          n_fail = 0, checks_done = 0, seed = 83594, d;
	int          lens[8] = '{4, 8, 16, 24, 32, 40, 48, 64};
	int          exp_q[$];
	logic [13:0] cfg_m = 14'h047f;
	always #20 mclk = ~mclk;
	bfpt_config uut (
		.mclk             (mclk),
		.rst_n            (rst_n),
		.reg_addr         (reg_addr),
		.reg_wdata        (reg_wdata),
		.reg_wr           (reg_wr),
		.reg_rd           (reg_rd),
		.reg_rdata        (reg_rdata),
		.fire_en          (fire_en),
		.pat_write_done   (pat_write_done),
		.pat_bits_written (pat_bits_written),
		.pll_enable       (pll_enable),
		.firing           (firing),
		.bit_strobe       (bit_strobe),
		.bit_index        (bit_index),
		.pattern_bits     (pattern_bits),
		.pattern_done     (pattern_done),
		.length_mismatch  (length_mismatch)
	);
	bfpt_host host (
		.mclk             (mclk),
		.reg_addr         (reg_addr),
		.reg_wdata        (reg_wdata),
		.reg_wr           (reg_wr),
		.reg_rd           (reg_rd),
		.pat_write_done   (pat_write_done),
		.pat_bits_written (pat_bits_written)
	);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic conclude();
		$display("checks=%0d fails=%0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic fire(input int l, input int n);
		int         cyc = 0, stb = 0;
		logic [6:0] pb = 7'h00;
		exp_q.push_back(l * n);
		fire_en <= 1'b1;
		for (int k = 0; !pattern_done; k++) begin
			if (k > 9000) begin
				n_fail++;
				conclude();
			end
			@(negedge mclk);
			cyc += firing;
			if (bit_strobe) chk(bit_index, stb);
			stb += bit_strobe;
			if (firing) pb = pattern_bits;
		end
		@(posedge mclk);
		fire_en <= 1'b0;
		repeat (3) @(posedge mclk);
		chk(cyc, exp_q.pop_front());
		chk(stb, l);
		chk(pb, l);
	endtask
	initial begin
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		host.acc(TOP_CONTROL_ADDR, 14'h0000, 1'b0);
		chk(reg_rdata, cfg_m);
		host.restart(cfg_m);
		chk(pll_enable, 1'b1);
		host.acc(5'h1b, 14'($random(seed)), 1'b1);
		host.acc(5'h1b, 14'h0000, 1'b0);
		chk(reg_rdata, 14'h0000);
		for (int c = 0; c < 8; c++) begin
			d = c == 7 ? 0 : c == 1 ? 16 : c == 0 ? 1 : 2 + {$random(seed)} % 3;
			cfg_m = {3'b000, c[0], d[6:0], c[2:0]};
			host.acc(TOP_CONTROL_ADDR, cfg_m, 1'b1);
			chk(pll_enable, c[0]);
			fire(lens[c], d == 0 ? 128 : d);
		end
		host.acc(TOP_CONTROL_ADDR, 14'h0412, 1'b1);
		fork
			fire(16, 2);
			begin
				repeat (6) @(posedge mclk);
				host.acc(TOP_CONTROL_ADDR, 14'h040b, 1'b1);
			end
		join
		host.acc(TOP_CONTROL_ADDR, 14'h0000, 1'b0);
		chk(reg_rdata, 14'h040b);
		fire(24, 1);
		host.pat(7'h18);
		chk(length_mismatch, 1'b0);
		host.pat(7'(7'h19 + {$random(seed)} % 8));
		chk(length_mismatch, 1'b1);
		conclude();
	end
endmodule
